/* File: src/uart2_dma_request_control.sv */
`timescale 1ns/1ps
module uart2_dma_request_control #(
    parameter int DATA_W = uart2_dma_pkg::DATA_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic [uart2_dma_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uart2_dma_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System DMA controller.
    input wire uart2_dma_pkg::tx_dma_in_s tx_dma_in,
    output logic tx_dma_req,
    input wire uart2_dma_pkg::rx_dma_in_s rx_dma_in,
    output logic rx_dma_req,
    output logic [DATA_W-1:0] rx_dma_rdata,
    // Second serial port FIFOs.
    input wire logic tx_fifo_space,
    output logic tx_fifo_wr,
    output logic [DATA_W-1:0] tx_fifo_wdata,
    input wire logic rx_fifo_avail,
    input wire logic [DATA_W-1:0] rx_fifo_rdata,
    output logic rx_fifo_rd,
    // Port mode and interrupt.
    output logic tx_hp_en,
    output logic rx_hp_en,
    output logic irq
);

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic aw_held_reg;
    logic [uart2_dma_pkg::ADDR_W-1:0] awaddr_reg;
    logic w_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic tx_fifo_wr_reg;
    logic [DATA_W-1:0] tx_fifo_wdata_reg;
    logic rx_fifo_rd_reg;
    logic [DATA_W-1:0] rx_dma_rdata_reg;

    // Write channel decode; the write is applied once address and data are both held.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_ctrl = wr_fire && (awaddr_reg == uart2_dma_pkg::CTRL_ADDR) && wstrb_reg[0];
    wire wr_stat = wr_fire && (awaddr_reg == uart2_dma_pkg::STAT_ADDR) && wstrb_reg[0];
    wire wr_mapped = (awaddr_reg == uart2_dma_pkg::CTRL_ADDR) || (awaddr_reg == uart2_dma_pkg::STAT_ADDR);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_ctrl = (s_axi_araddr == uart2_dma_pkg::CTRL_ADDR);
    wire rd_stat = (s_axi_araddr == uart2_dma_pkg::STAT_ADDR);

    // Holding a channel blocks its ready so the other may arrive in any order.
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Enables taken from the control register.
    wire tx_en = ctrl_reg[uart2_dma_pkg::CTRL_TX_EN];
    wire rx_en = ctrl_reg[uart2_dma_pkg::CTRL_RX_EN];
    wire tx_ie = ctrl_reg[uart2_dma_pkg::CTRL_TX_IE];
    wire rx_ie = ctrl_reg[uart2_dma_pkg::CTRL_RX_IE];
    wire tx_ack_ok = tx_en && tx_dma_in.ack;
    wire rx_ack_ok = rx_en && rx_dma_in.ack && rx_fifo_avail;

    // Requests follow FIFO levels combinationally, so they drop the same cycle the enable does.
    assign tx_dma_req = tx_en && tx_fifo_space;
    assign rx_dma_req = rx_en && rx_fifo_avail;
    assign tx_hp_en = ctrl_reg[uart2_dma_pkg::CTRL_TX_HP];
    assign rx_hp_en = ctrl_reg[uart2_dma_pkg::CTRL_RX_HP];
    assign tx_fifo_wr = tx_fifo_wr_reg;
    assign tx_fifo_wdata = tx_fifo_wdata_reg;
    assign rx_fifo_rd = rx_fifo_rd_reg;
    assign rx_dma_rdata = rx_dma_rdata_reg;

    // Interrupt: each flag gated by its own enable, then ORed.
    assign irq = (stat_reg[uart2_dma_pkg::STAT_TX_DONE] && tx_ie)
        || (stat_reg[uart2_dma_pkg::STAT_RX_DONE] && rx_ie);

    // Next control value: only the writable bits take the bus data.
    assign ctrl_next = wr_ctrl ? (wdata_reg[7:0] & uart2_dma_pkg::CTRL_RW_MASK) : ctrl_reg;

    // Next status: a finish event wins over a write-one clear in the same cycle.
    // The enable bit of the next control value also clears, so disabling clears at once.
    always_comb begin
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~(wdata_reg[7:0] & uart2_dma_pkg::STAT_W1C_MASK);
        end
        if (!ctrl_next[uart2_dma_pkg::CTRL_TX_EN]) begin
            stat_next[uart2_dma_pkg::STAT_TX_DONE] = 1'b0;
        end else if (tx_en && tx_dma_in.done) begin
            stat_next[uart2_dma_pkg::STAT_TX_DONE] = 1'b1;
        end
        if (!ctrl_next[uart2_dma_pkg::CTRL_RX_EN]) begin
            stat_next[uart2_dma_pkg::STAT_RX_DONE] = 1'b0;
        end else if (rx_en && rx_dma_in.done) begin
            stat_next[uart2_dma_pkg::STAT_RX_DONE] = 1'b1;
        end
    end

    // Register file.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= uart2_dma_pkg::CTRL_RESET;
            stat_reg <= uart2_dma_pkg::STAT_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
        end
    end

    // Write address and data capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= uart2_dma_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? uart2_dma_pkg::RESP_OKAY : uart2_dma_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel; reserved bits come back as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= uart2_dma_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            if (rd_ctrl) begin
                rdata_reg <= {24'h00_0000, ctrl_reg};
                rresp_reg <= uart2_dma_pkg::RESP_OKAY;
            end else if (rd_stat) begin
                rdata_reg <= {24'h00_0000, stat_reg};
                rresp_reg <= uart2_dma_pkg::RESP_OKAY;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= uart2_dma_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Data movement on acknowledge; one item per acknowledged cycle.
    // A receive acknowledge is taken only while the receive FIFO has data available.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_fifo_wr_reg <= 1'b0;
            tx_fifo_wdata_reg <= '0;
            rx_fifo_rd_reg <= 1'b0;
            rx_dma_rdata_reg <= '0;
        end else begin
            tx_fifo_wr_reg <= tx_ack_ok;
            rx_fifo_rd_reg <= rx_ack_ok;
            if (tx_ack_ok) begin
                tx_fifo_wdata_reg <= tx_dma_in.wdata;
            end
            if (rx_ack_ok) begin
                rx_dma_rdata_reg <= rx_fifo_rdata;
            end
        end
    end

    // Checks; all of them live in the one clock domain and are quiet during reset.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A disabled transmit channel never asks for data.
    tx_req_gate_a: assert property (!tx_en |-> !tx_dma_req)
        else $error("transmit request while transmit DMA disabled");

    // A disabled receive channel never asks for data.
    rx_req_gate_a: assert property (!rx_en |-> !rx_dma_req)
        else $error("receive request while receive DMA disabled");

    // Space in the transmit FIFO must raise the request at once.
    tx_req_space_a: assert property (tx_en && tx_fifo_space |-> tx_dma_req)
        else $error("transmit request missing with space available");

    // Data in the receive FIFO must raise the request at once.
    rx_req_avail_a: assert property (rx_en && rx_fifo_avail |-> rx_dma_req)
        else $error("receive request missing with data available");

    // An acknowledge on a disabled transmit channel moves nothing.
    tx_ack_ignore_a: assert property (!tx_en && tx_dma_in.ack |=> !tx_fifo_wr)
        else $error("transmit acknowledge honoured while disabled");

    // An acknowledge on a disabled receive channel moves nothing.
    rx_ack_ignore_a: assert property (!rx_en && rx_dma_in.ack |=> !rx_fifo_rd)
        else $error("receive acknowledge honoured while disabled");

    // A FIFO write strobe only ever follows an accepted acknowledge.
    tx_wr_cause_a: assert property (!$past(tx_ack_ok) |-> !tx_fifo_wr)
        else $error("transmit FIFO write without accepted acknowledge");

    // A FIFO read strobe only ever follows an accepted acknowledge.
    rx_rd_cause_a: assert property (!$past(rx_ack_ok) |-> !rx_fifo_rd)
        else $error("receive FIFO read without accepted acknowledge");

    // The item delivered with the acknowledge reaches the FIFO one cycle later.
    tx_data_move_a: assert property (tx_en && tx_dma_in.ack |=> tx_fifo_wr && tx_fifo_wdata == $past(tx_dma_in.wdata))
        else $error("transmit data not passed on acknowledge");

    // The FIFO head is handed to the controller one cycle after its acknowledge.
    rx_data_move_a: assert property (rx_ack_ok |=> rx_fifo_rd && rx_dma_rdata == $past(rx_fifo_rdata))
        else $error("receive data not supplied on acknowledge");

    // Transmit data holds between transfers so a late reader still sees the last item.
    tx_data_hold_a: assert property (!tx_ack_ok |=> $stable(tx_fifo_wdata))
        else $error("transmit data changed without acknowledge");

    // Receive data holds between transfers.
    rx_data_hold_a: assert property (!rx_ack_ok |=> $stable(rx_dma_rdata))
        else $error("receive data changed without acknowledge");

    // A transmit finish sets its flag unless the enable is being rewritten.
    tx_done_set_a: assert property (tx_en && tx_dma_in.done && !wr_ctrl
        |=> stat_reg[uart2_dma_pkg::STAT_TX_DONE])
        else $error("transmit finish did not set flag");

    // A receive finish sets its flag unless the enable is being rewritten.
    rx_done_set_a: assert property (rx_en && rx_dma_in.done && !wr_ctrl
        |=> stat_reg[uart2_dma_pkg::STAT_RX_DONE])
        else $error("receive finish did not set flag");

    // A disabled transmit channel holds no completion flag.
    tx_flag_clear_a: assert property (!tx_en |-> !stat_reg[uart2_dma_pkg::STAT_TX_DONE])
        else $error("transmit flag set while transmit DMA disabled");

    // A disabled receive channel holds no completion flag.
    rx_flag_clear_a: assert property (!rx_en |-> !stat_reg[uart2_dma_pkg::STAT_RX_DONE])
        else $error("receive flag set while receive DMA disabled");

    // Writing one clears the transmit flag when no finish arrives in the same cycle.
    tx_w1c_a: assert property (wr_stat && wdata_reg[uart2_dma_pkg::STAT_TX_DONE] && !tx_dma_in.done
        |=> !stat_reg[uart2_dma_pkg::STAT_TX_DONE])
        else $error("transmit flag survived a write of one");

    // Writing one clears the receive flag when no finish arrives in the same cycle.
    rx_w1c_a: assert property (wr_stat && wdata_reg[uart2_dma_pkg::STAT_RX_DONE] && !rx_dma_in.done
        |=> !stat_reg[uart2_dma_pkg::STAT_RX_DONE])
        else $error("receive flag survived a write of one");

    // Writing zero to a set transmit flag leaves it set.
    zero_keeps_a: assert property (wr_stat && !wdata_reg[1] && stat_reg[1] && tx_en |=> stat_reg[1])
        else $error("transmit flag lost on a write of zero");

    // The interrupt is exactly the two gated flags ORed together.
    irq_combine_a: assert property (irq == ((stat_reg[1] && ctrl_reg[3]) || (stat_reg[0] && ctrl_reg[2])))
        else $error("interrupt does not follow gated flags");

    // With both flags clear the interrupt stays low whatever the gates say.
    irq_idle_a: assert property (!stat_reg[1] && !stat_reg[0] |-> !irq)
        else $error("interrupt raised with no flag set");

    // Reserved bits never hold a one.
    reserved_zero_a: assert property (ctrl_reg[7:6] == 2'b00 && stat_reg[7:2] == 6'h00)
        else $error("reserved bits not zero");

    // The port mode outputs mirror their control bits.
    hp_follow_a: assert property (tx_hp_en == ctrl_reg[5] && rx_hp_en == ctrl_reg[4])
        else $error("high-performance enables do not follow control");

    // A control write stores only the writable bits.
    ctrl_write_a: assert property (wr_ctrl |=> ctrl_reg == ($past(wdata_reg[7:0]) & uart2_dma_pkg::CTRL_RW_MASK))
        else $error("control write stored wrong value");

    // Nothing but a control write changes the control register.
    ctrl_keep_a: assert property (!wr_ctrl |=> $stable(ctrl_reg))
        else $error("control register changed without a write");

    // A write with byte lane zero disabled leaves control alone.
    strobe_lane_a: assert property (wr_fire && !wstrb_reg[0] |=> $stable(ctrl_reg))
        else $error("control changed by a write with lane zero off");

    // Every completed write gets its response.
    write_resp_a: assert property (wr_fire |=> s_axi_bvalid)
        else $error("write response missing");

    // Writes outside the map answer with a slave error.
    unmapped_resp_a: assert property (wr_fire && !wr_mapped |=> s_axi_bresp == uart2_dma_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");

    // The write response stands until the master takes it.
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    // Every taken read address gets its data one cycle later.
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");

    // The read answer stands until the master takes it.
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    // Main scenarios to be seen at least once.
    tx_transfer_c: cover property (tx_dma_req ##[1:4] tx_fifo_wr);
    rx_transfer_c: cover property (rx_dma_req ##[1:4] rx_fifo_rd);
    irq_raise_c: cover property (!irq ##1 irq);
    set_beats_clear_c: cover property (wr_stat && wdata_reg[1] && tx_en && tx_dma_in.done);
    tx_back_to_back_c: cover property (tx_fifo_wr ##1 tx_fifo_wr);

endmodule // uart2_dma_request_control

/* File: src/uart2_dma_pkg.sv */
package uart2_dma_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [3:0] CTRL_INDEX = 4'h2;
    localparam logic [3:0] STAT_INDEX = 4'h3;
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({CTRL_INDEX, 2'b00});
    localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'({STAT_INDEX, 2'b00});

    // Control register field positions.
    localparam int CTRL_TX_HP = 5;
    localparam int CTRL_RX_HP = 4;
    localparam int CTRL_TX_IE = 3;
    localparam int CTRL_RX_IE = 2;
    localparam int CTRL_TX_EN = 1;
    localparam int CTRL_RX_EN = 0;
    localparam logic [7:0] CTRL_RW_MASK = 8'h3f;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register field positions.
    localparam int STAT_TX_DONE = 1;
    localparam int STAT_RX_DONE = 0;
    localparam logic [7:0] STAT_W1C_MASK = 8'h03;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int DATA_W = 8;

    // Transmit side of the DMA controller handshake.
    typedef struct packed {
        logic ack;
        logic done;
        logic [DATA_W-1:0] wdata;
    } tx_dma_in_s;

    // Receive side of the DMA controller handshake.
    typedef struct packed {
        logic ack;
        logic done;
    } rx_dma_in_s;

endpackage

/* File: dv/dma_ctrl_model.sv */
`timescale 1ns/1ps
// Stand-in for the system DMA controller: answers requests with acknowledges, promptly or slowly.
module dma_ctrl_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic wrong,
    input wire logic tx_done_cmd,
    input wire logic rx_done_cmd,
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    output uart2_dma_pkg::tx_dma_in_s tx_dma_in,
    output uart2_dma_pkg::rx_dma_in_s rx_dma_in
);
    logic [7:0] pat_reg;

    // Data changes every cycle, so a stale item can never pass for a fresh one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pat_reg <= 8'h5a;
            tx_dma_in <= '0;
            rx_dma_in <= '0;
        end else begin
            pat_reg <= pat_reg + 8'h3b;
            tx_dma_in.ack <= go & (tx_dma_req | wrong);
            tx_dma_in.wdata <= pat_reg;
            tx_dma_in.done <= tx_done_cmd;
            rx_dma_in.ack <= go & (rx_dma_req | wrong);
            rx_dma_in.done <= rx_done_cmd;
        end
    end
endmodule // dma_ctrl_model

/* File: dv/test_uart2_dma_request_control.sv */
`timescale 1ns/1ps
module test_uart2_dma_request_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, tx_req, rx_req, tx_wr, rx_rd, tx_hp, rx_hp, irq;
    logic [1:0] bresp, rresp;
    uart2_dma_pkg::tx_dma_in_s tx_in;
    uart2_dma_pkg::rx_dma_in_s rx_in;
    logic [7:0] rx_dout, tx_dout, v, rx_head = '0, ctrl_exp = '0, exp_txd = '0, exp_rxd = '0;
    logic space = 0, avail = 0, go = 0, wrong = 0, txc = 0, rxc = 0, mon = 0, exp_tx = 0, exp_rx = 0;
    int error_cnt = 0, total_checks = 0, seed = 78, cyc = 0;

    always #20 aclk = ~aclk;

    uart2_dma_request_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_dma_in(tx_in), .tx_dma_req(tx_req), .rx_dma_in(rx_in), .rx_dma_req(rx_req),
        .rx_dma_rdata(rx_dout), .tx_fifo_space(space), .tx_fifo_wr(tx_wr), .tx_fifo_wdata(tx_dout),
        .rx_fifo_avail(avail), .rx_fifo_rdata(rx_head), .rx_fifo_rd(rx_rd), .tx_hp_en(tx_hp),
        .rx_hp_en(rx_hp), .irq(irq));

    dma_ctrl_model partner (.aclk(aclk), .aresetn(aresetn), .go(go), .wrong(wrong), .tx_done_cmd(txc),
        .rx_done_cmd(rxc), .tx_dma_req(tx_req), .rx_dma_req(rx_req), .tx_dma_in(tx_in), .rx_dma_in(rx_in));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    // Watches the DMA link while streaming; FIFO strobes lag the taken acknowledge by one cycle.
    always @(posedge aclk) begin
        if (mon) begin
            chk("tx_req", tx_req, ctrl_exp[1] & space);
            chk("rx_req", rx_req, ctrl_exp[0] & avail);
            chk("tx_wr", tx_wr, exp_tx);
            chk("rx_rd", rx_rd, exp_rx);
            if (exp_tx) chk("tx_data", tx_dout, exp_txd);
            if (exp_rx) chk("rx_data", rx_dout, exp_rxd);
        end
        exp_tx <= tx_in.ack & ctrl_exp[1];
        exp_txd <= tx_in.wdata;
        exp_rx <= rx_in.ack & ctrl_exp[0] & avail;
        exp_rxd <= rx_head;
    end

    // Address and data are offered together and each released once taken.
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask

    task automatic axi_rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, ed);
        chk("rresp", rresp, er);
    endtask

    task automatic wc(input logic [7:0] d);
        axi_wr(uart2_dma_pkg::CTRL_ADDR, {24'h0, d}, uart2_dma_pkg::RESP_OKAY);
        ctrl_exp <= d & 8'h3f;
    endtask

    task automatic ws(input logic [7:0] d);
        axi_wr(uart2_dma_pkg::STAT_ADDR, {24'h0, d}, uart2_dma_pkg::RESP_OKAY);
    endtask

    task automatic st(input logic [7:0] es, input logic ei);
        axi_rd(uart2_dma_pkg::STAT_ADDR, {24'h0, es}, uart2_dma_pkg::RESP_OKAY);
        chk("irq", irq, ei);
    endtask

    // One done pulse from the controller, then time for the flag to land.
    task automatic pulse(input logic t);
        @(posedge aclk);
        txc <= t;
        rxc <= !t;
        @(posedge aclk);
        txc <= 1'b0;
        rxc <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic stream(input int n);
        mon <= 1'b1;
        repeat (n) begin
            @(posedge aclk);
            space <= 1'($random(seed));
            avail <= 1'($random(seed));
            rx_head <= 8'($random(seed));
            go <= 1'($random(seed));
        end
        @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
        mon <= 1'b0;
        $display("test stream ctrl %h done", ctrl_exp);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(uart2_dma_pkg::CTRL_ADDR, 32'h0000_0000, uart2_dma_pkg::RESP_OKAY);
        st(8'h00, 1'b0);
        axi_rd(6'h00, 32'h0000_0000, uart2_dma_pkg::RESP_SLVERR);
        axi_wr(6'h3c, 32'hffff_ffff, uart2_dma_pkg::RESP_SLVERR);
        repeat (8) begin
            v = 8'($random(seed));
            wc(v);
            axi_rd(uart2_dma_pkg::CTRL_ADDR, {24'h0, v & 8'h3f}, uart2_dma_pkg::RESP_OKAY);
            chk("tx_hp", tx_hp, v[5]);
            chk("rx_hp", rx_hp, v[4]);
        end
        // A write with byte lane zero switched off must leave control untouched.
        wstrb <= 4'he;
        axi_wr(uart2_dma_pkg::CTRL_ADDR, 32'h0000_003f, uart2_dma_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(uart2_dma_pkg::CTRL_ADDR, {24'h0, ctrl_exp}, uart2_dma_pkg::RESP_OKAY);
        $display("test registers done");
        // Acks forced onto disabled channels must move nothing.
        wc(8'h00);
        wrong <= 1'b1;
        stream(60);
        wrong <= 1'b0;
        wc(8'h03);
        stream(120);
        wc(8'h01);
        stream(40);
        wc(8'h02);
        stream(40);
        wc(8'h0f);
        pulse(1'b1);
        st(8'h02, 1'b1);
        ws(8'h00);
        st(8'h02, 1'b1);
        wc(8'h07);
        st(8'h02, 1'b0);
        ws(8'h02);
        st(8'h00, 1'b0);
        wc(8'h0f);
        pulse(1'b0);
        st(8'h01, 1'b1);
        wc(8'h0b);
        st(8'h01, 1'b0);
        wc(8'h0a);
        st(8'h00, 1'b0);
        pulse(1'b1);
        st(8'h02, 1'b1);
        wc(8'h09);
        st(8'h00, 1'b0);
        pulse(1'b1);
        st(8'h00, 1'b0);
        $display("test status_irq done");
        // Reset in mid-run with a flag set must bring every register back to zero.
        wc(8'h3f);
        pulse(1'b1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        ctrl_exp <= 8'h00;
        axi_rd(uart2_dma_pkg::CTRL_ADDR, 32'h0000_0000, uart2_dma_pkg::RESP_OKAY);
        st(8'h00, 1'b0);
        chk("tx_hp", tx_hp, 1'b0);
        chk("rx_hp", rx_hp, 1'b0);
        $display("test reset done");
        finish_test();
    end
endmodule // test_uart2_dma_request_control
